/* File: rtl/mpp_consts.vh */
`ifndef MPP_CONSTS_VH
`define MPP_CONSTS_VH
// Register byte offsets
`define MPP_OFF_CTRL 12'h000
`define MPP_OFF_DESC0 12'h004
`define MPP_OFF_DESC1 12'h008
`define MPP_OFF_MSG 12'h00c
`define MPP_OFF_STATUS 12'h010
`define MPP_OFF_LAST 12'h014
// Control fields
`define MPP_CTRL_EN 0
`define MPP_CTRL_WEP 1
`define MPP_NPL_LO 8
`define MPP_INT_LO 16
// Encoded address fields
`define MPP_PRI_LO 4
`define MPP_PRI_HI 8
`define MPP_ID_LO 14
`define MPP_ID_HI 23
// Condition codes
`define MPP_CC_ACK 3'h2
`define MPP_CC_NACK 3'h0
// Reset value and priority broadcast address
`define MPP_MSG_RST 32'h85000000
`define MPP_EXT_PRI_ADDR 32'hff000010
`endif

/* File: rtl/mpp_preempt.v */
// The APB slave port and the register offsets were left to the implementer.
`timescale 1ns/1ps
// What the document requires
// R01: Only a process whose preempt flag is set may start a preemption sequence.
// R02: With preempt enable set, the whole sequence runs in hardware alone.
// R03: The request carries the preempt-process message word from the descriptor.
// R04: Descriptor is three words: two target addresses, then the message word.
// R05: Address priority is normally low; priority 1 reaches only idle processors.
// R06: Refuse incoming request at or below current priority or threshold.
// R07: Broadcast current priority on switch, non-message interrupt, controls modify.
// R08: Broadcast interim priority on send, send-service, signal, schedule.
// R09: A scheduled preempting process first goes to the first descriptor address.
// R10: Filter agent forwards higher-priority requests and acknowledges the sender.
// R11: Accepted receiver dispatches if port priority is higher, else resumes; the code also requires rx_blocked low to dispatch.
// R12: On acknowledge the sender stops the sequence and resumes.
// R13: Filter agent not-acknowledges when receiver priority is higher.
// R14: After refusal from the first target, send to the second address.
// R15: Then retry first, then second, with the preempting process priority.
// R16: After four refusals abandon the search and resume.
// R17: A suspended preempt-eligible process starts the same sequence again.
// R18: Target processor identity is bits 14 to 23 of the address.
// R19: Message priority sits in bits 4 to 8 of the address.
// R20: Outcome code is 010 binary for accepted, 000 binary for refused.
// R21: Each attempt stalls until acknowledge or not-acknowledge arrives.
// R22: Configuration is held stable throughout one sequence.
`include "mpp_consts.vh"
module mpp_preempt #(
	parameter PW = 5
) (
	input wire pclk,
	input wire presetn,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [11:0] paddr,
	input wire [31:0] pwdata,
	output reg [31:0] prdata,
	output reg pready,
	output reg pslverr,
	input wire sched_preempt,
	input wire sched_eligible,
	input wire [PW-1:0] sched_pri,
	input wire [PW-1:0] cur_pri,
	input wire ev_switch,
	input wire ev_int,
	input wire ev_modpc,
	input wire ev_queue_op,
	input wire rx_req,
	input wire [31:0] rx_addr,
	input wire [PW-1:0] port_pri,
	input wire rx_blocked,
	input wire rx_susp_eligible,
	input wire [PW-1:0] rx_susp_pri,
	output reg rx_accept,
	output reg rx_reject,
	output reg rx_dispatch,
	output reg tx_req,
	output reg [31:0] tx_addr,
	output reg [31:0] tx_data,
	input wire tx_ack,
	input wire tx_nack,
	output reg [2:0] cond_code,
	output reg busy,
	output reg resume
);
	localparam S_IDLE = 2'd0;
	localparam S_SEND = 2'd1;
	localparam S_WAIT = 2'd2;

	reg [31:0] ctrl;
	reg [31:0] desc0;
	reg [31:0] desc1;
	reg [31:0] msg;
	reg [1:0] state;
	reg [1:0] step;
	reg [PW-1:0] pend_pri;
	reg [31:0] cfg_lock;
	reg ext_pend;
	reg [31:0] ext_word;
	reg [31:0] next_rdata;
	reg [31:0] sel_addr;
	wire en_cfg;
	wire wep_cfg;
	wire [PW-1:0] npl;
	wire [PW-1:0] interim;
	wire wr;
	wire start_local;
	wire start_chain;
	wire rx_ok;

	// Priority above both current level and threshold
	function higher;
		input [PW-1:0] p;
		input [PW-1:0] cur;
		input [PW-1:0] lim;
		begin
			higher = (p > cur) && (p > lim);
		end
	endfunction

	// Replace the priority field of an encoded address
	function [31:0] with_pri;
		input [31:0] a;
		input [PW-1:0] p;
		begin
			with_pri = a;
			with_pri[`MPP_PRI_HI:`MPP_PRI_LO] = p[4:0];
		end
	endfunction

	assign wr = psel && penable && pwrite;
	assign en_cfg = cfg_lock[`MPP_CTRL_EN];
	assign wep_cfg = cfg_lock[`MPP_CTRL_WEP];
	assign npl = cfg_lock[`MPP_NPL_LO+PW-1:`MPP_NPL_LO];
	assign interim = cfg_lock[`MPP_INT_LO+PW-1:`MPP_INT_LO];
	assign start_local = sched_preempt && sched_eligible && en_cfg; // R01 R02 R09
	assign start_chain = rx_dispatch && rx_susp_eligible && en_cfg; // R17
	assign rx_ok = higher(rx_addr[`MPP_PRI_HI:`MPP_PRI_LO], cur_pri, npl); // R06 R19

	////////////////////////////////////////////////////////////////////
	// APB register access, one wait-free cycle
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl <= 32'h00000000;
			desc0 <= 32'h00000000;
			desc1 <= 32'h00000000;
			msg <= `MPP_MSG_RST;
			prdata <= 32'h00000000;
			pready <= 1'b0;
			pslverr <= 1'b0;
		end else begin
			pready <= psel && !penable;
			pslverr <= 1'b0;
			if (psel && !penable) begin
				prdata <= next_rdata;
				pslverr <= (paddr > `MPP_OFF_LAST) || (paddr[1:0] != 2'b00);
			end
			if (wr && pready) begin
				case (paddr)
				`MPP_OFF_CTRL: ctrl <= pwdata;
				`MPP_OFF_DESC0: desc0 <= pwdata; // R04
				`MPP_OFF_DESC1: desc1 <= pwdata; // R04
				`MPP_OFF_MSG: msg <= pwdata; // R03
				default: ;
				endcase
			end
		end
	end

	// Read data decode
	always @* begin
		case (paddr)
		`MPP_OFF_CTRL: next_rdata = ctrl;
		`MPP_OFF_DESC0: next_rdata = desc0;
		`MPP_OFF_DESC1: next_rdata = desc1;
		`MPP_OFF_MSG: next_rdata = msg;
		`MPP_OFF_STATUS: next_rdata = {24'h000000, 1'b0, cond_code, step, state};
		`MPP_OFF_LAST: next_rdata = {22'h000000, rx_addr[`MPP_ID_HI:`MPP_ID_LO]}; // R18
		default: next_rdata = 32'h00000000;
		endcase
	end

	// Target address of the current attempt
	always @* begin
		case (step)
		2'd0: sel_addr = cfg_lock[`MPP_CTRL_EN] ? desc0 : desc0; // R09 R05
		2'd1: sel_addr = desc1; // R14
		2'd2: sel_addr = with_pri(desc0, pend_pri); // R15
		default: sel_addr = with_pri(desc1, pend_pri); // R15
		endcase
	end

	////////////////////////////////////////////////////////////////////
	// Sender sequence and priority broadcast
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state <= S_IDLE;
			step <= 2'd0;
			pend_pri <= {PW{1'b0}};
			cfg_lock <= 32'h00000000;
			tx_req <= 1'b0;
			tx_addr <= 32'h00000000;
			tx_data <= 32'h00000000;
			cond_code <= `MPP_CC_NACK;
			busy <= 1'b0;
			resume <= 1'b0;
			ext_pend <= 1'b0;
			ext_word <= 32'h00000000;
		end else begin
			resume <= 1'b0;
			if (state == S_IDLE)
				cfg_lock <= ctrl; // R22
			// Latch broadcasts; queue op value overrides
			if (wep_cfg && ev_queue_op) begin
				ext_pend <= 1'b1;
				ext_word <= {{(32-PW){1'b0}}, interim}; // R08
			end else if (wep_cfg && (ev_switch || ev_int || ev_modpc)) begin
				ext_pend <= 1'b1;
				ext_word <= {{(32-PW){1'b0}}, cur_pri}; // R07
			end
			case (state)
			S_IDLE: begin
				if (start_local || start_chain) begin
					step <= 2'd0;
					pend_pri <= start_chain ? rx_susp_pri : sched_pri;
					busy <= 1'b1;
					state <= S_SEND;
				end else if (ext_pend && !tx_req) begin
					tx_req <= 1'b1;
					tx_addr <= `MPP_EXT_PRI_ADDR;
					tx_data <= ext_word;
					// A broadcast event in this same cycle keeps the flag set
					ext_pend <= wep_cfg && (ev_queue_op || ev_switch || ev_int || ev_modpc);
					state <= S_WAIT;
				end
			end
			S_SEND: begin
				tx_req <= 1'b1;
				tx_addr <= sel_addr;
				tx_data <= msg; // R03
				state <= S_WAIT;
			end
			S_WAIT: begin
				if (tx_ack || tx_nack) begin // R21
					tx_req <= 1'b0;
					cond_code <= tx_ack ? `MPP_CC_ACK : `MPP_CC_NACK; // R20
					if (!busy) begin
						state <= S_IDLE;
					end else if (tx_ack || step == 2'd3) begin
						busy <= 1'b0; // R12 R16
						resume <= 1'b1;
						state <= S_IDLE;
					end else begin
						step <= step + 2'd1; // R14 R15
						state <= S_SEND;
					end
				end
			end
			default: state <= S_IDLE;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////
	// Receiver decision on incoming preemption requests
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rx_accept <= 1'b0;
			rx_reject <= 1'b0;
			rx_dispatch <= 1'b0;
		end else begin
			rx_accept <= rx_req && rx_ok;
			rx_reject <= rx_req && !rx_ok; // R06
			rx_dispatch <= rx_req && rx_ok && !rx_blocked
				&& higher(port_pri, cur_pri, npl); // R11
		end
	end
endmodule

/* File: bench/mpp_preempt_props.sv */
`timescale 1ns/1ps
module mpp_preempt_props #(
	parameter PW = 5
) (
	input wire pclk,
	input wire presetn,
	input wire sched_preempt,
	input wire sched_eligible,
	input wire [PW-1:0] cur_pri,
	input wire rx_req,
	input wire [31:0] rx_addr,
	input wire rx_accept,
	input wire rx_reject,
	input wire rx_dispatch,
	input wire tx_req,
	input wire [31:0] tx_addr,
	input wire tx_ack,
	input wire tx_nack,
	input wire [2:0] cond_code,
	input wire busy,
	input wire resume
);
default clocking @(posedge pclk); endclocking
default disable iff (!presetn);
AST_HOLD: assert property (tx_req && !tx_ack && !tx_nack |=> tx_req && $stable(tx_addr))
	else $error("request not held");
AST_ACK: assert property (busy && tx_ack |=> resume && cond_code == 3'h2)
	else $error("ack not finished");
AST_NACK: assert property (busy && tx_nack |=> cond_code == 3'h0)
	else $error("nack code wrong");
AST_IDLE: assert property (!busy && sched_preempt && !sched_eligible |=> !busy)
	else $error("ineligible start");
AST_REJ: assert property (rx_req && rx_addr[8:4] <= cur_pri |=> rx_reject && !rx_accept)
	else $error("low request taken");
AST_ONE: assert property (rx_req |=> rx_accept != rx_reject)
	else $error("no single answer");
AST_DISP: assert property (rx_dispatch |-> $past(rx_req))
	else $error("stray dispatch");
AST_RES: assert property (resume |-> !busy && !tx_req)
	else $error("resume while active");
// Main scenarios
cover property (busy && tx_ack);
cover property (busy && tx_nack);
cover property (rx_dispatch);
endmodule
bind mpp_preempt mpp_preempt_props #(.PW(PW)) u_mpp_preempt_props (.pclk, .presetn,
	.sched_preempt, .sched_eligible, .cur_pri, .rx_req, .rx_addr, .rx_accept, .rx_reject,
	.rx_dispatch, .tx_req, .tx_addr, .tx_ack, .tx_nack, .cond_code, .busy, .resume);

/* File: bench/mpp_agent.sv */
`timescale 1ns/1ps
`include "mpp_consts.vh"
module mpp_agent (
	input wire pclk,
	input wire presetn,
	input wire tx_req,
	input wire [31:0] tx_addr,
	input wire [4:0] pa,
	input wire [4:0] pb,
	input wire slow,
	output reg tx_ack,
	output reg tx_nack
);
reg [3:0] cnt;
reg done;
wire [4:0] trk = tx_addr[14] ? pb : pa;
wire ok = tx_addr[8:4] > trk || tx_addr == `MPP_EXT_PRI_ADDR;
// Answer each held request once, promptly or after five cycles
always @(posedge pclk or negedge presetn) begin
	if (!presetn) begin
		{cnt, done, tx_ack, tx_nack} <= 0;
	end else begin
		tx_ack <= 0;
		tx_nack <= 0;
		if (!tx_req) begin
			cnt <= 0;
			done <= 0;
		end else if (!done && cnt >= (slow ? 4'h5 : 4'h0)) begin
			done <= 1;
			tx_ack <= ok;
			tx_nack <= !ok;
		end else begin
			cnt <= cnt + 1;
		end
	end
end
endmodule

/* File: bench/mpp_preempt_bench.sv */
`timescale 1ns/1ps
`include "mpp_consts.vh"
module mpp_preempt_bench;
localparam D0 = 32'hff010010;
localparam D1 = 32'hff014010;
reg pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
reg [11:0] paddr = 0;
reg [31:0] pwdata = 0, rx_addr = 0, a;
reg sp = 0, se = 1, rx_req = 0, slow = 0, sus = 0, blk = 0;
reg [3:0] ev = 0;
reg [4:0] sched_pri = 0, cur_pri = 5, port_pri = 0, pa = 0, pb = 0;
wire [31:0] prdata, tx_addr, tx_data;
wire pready, pslverr, rx_accept, rx_reject, rx_dispatch, tx_req, tx_ack, tx_nack;
wire busy, resume;
wire [2:0] cond_code;
int err_count = 0, compares = 0, i, n;
mpp_preempt u_mpp_preempt (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
	.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
	.pslverr(pslverr), .sched_preempt(sp), .sched_eligible(se), .sched_pri(sched_pri),
	.cur_pri(cur_pri), .ev_switch(ev[0]), .ev_int(ev[2]), .ev_modpc(ev[3]),
	.ev_queue_op(ev[1]), .rx_req(rx_req), .rx_addr(rx_addr), .port_pri(port_pri),
	.rx_blocked(blk), .rx_susp_eligible(sus), .rx_susp_pri(sched_pri),
	.rx_accept(rx_accept), .rx_reject(rx_reject), .rx_dispatch(rx_dispatch),
	.tx_req(tx_req), .tx_addr(tx_addr), .tx_data(tx_data), .tx_ack(tx_ack),
	.tx_nack(tx_nack), .cond_code(cond_code), .busy(busy), .resume(resume));
mpp_agent u_mpp_agent (.pclk(pclk), .presetn(presetn), .tx_req(tx_req), .tx_addr(tx_addr),
	.pa(pa), .pb(pb), .slow(slow), .tx_ack(tx_ack), .tx_nack(tx_nack));
initial forever #12.5 pclk = ~pclk;
////////////////////////////////////////////////////////////////
task complete_run;
	begin
		$display("compares %0d err_count %0d", compares, err_count);
		if (err_count == 0 && compares > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	end
endtask
task chk(input [31:0] g, input [31:0] e);
	begin
		compares++;
		if (g !== e) begin
			err_count++;
			$display("[FAIL] %0t got %h exp %h", $time, g, e);
		end
	end
endtask
task tick;
	begin
		@(posedge pclk);
		n++;
		if (n > 60) begin
			err_count++;
			complete_run;
		end
	end
endtask
task apb(input w, input [11:0] ad, input [31:0] d, input [31:0] e, input er);
	begin
		@(posedge pclk) {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, ad, d};
		@(posedge pclk) penable <= 1;
		n = 0;
		do tick; while (pready !== 1);
		if (!w && !er) chk(prdata, e);
		chk(pslverr, er);
		{psel, penable} <= 2'b00;
	end
endtask
task wt(input v);
	begin
		n = 0;
		while (tx_req !== v) tick;
	end
endtask
task att(input [31:0] ea, input [31:0] ed);
	begin
		wt(1);
		chk(tx_addr, ea);
		chk(tx_data, ed);
		wt(0);
	end
endtask
task pulse_sched;
	begin
		@(posedge pclk) sp <= 1;
		@(posedge pclk) sp <= 0;
	end
endtask
task tries(input int k, input [2:0] cc);
	begin
		for (i = 0; i < k; i++) begin
			a = i[0] ? D1 : D0;
			if (i > 1) a[8:4] = sched_pri;
			att(a, 32'h85000000);
			chk(resume, i == k - 1);
			chk(cond_code, i == k - 1 ? cc : 3'h0);
		end
	end
endtask
task seq(input int k, input [2:0] cc);
	begin
		pulse_sched;
		tries(k, cc);
	end
endtask
task rx(input [4:0] p, input [4:0] pp, input [2:0] e);
	begin
		@(posedge pclk) rx_req <= 1;
		{rx_addr, port_pri} <= {D0[31:9], p, 4'h0, pp};
		@(posedge pclk) rx_req <= 0;
		@(posedge pclk);
		chk({rx_accept, rx_reject, rx_dispatch}, e);
	end
endtask
task bc(input [3:0] e, input [31:0] d);
	begin
		@(posedge pclk) ev <= e;
		@(posedge pclk) ev <= 0;
		att(`MPP_EXT_PRI_ADDR, d);
	end
endtask
////////////////////////////////////////////////////////////////
initial begin
	repeat (20) @(posedge pclk);
	presetn <= 1;
	apb(0, `MPP_OFF_MSG, 0, 32'h85000000, 0);
	apb(0, 12'h020, 0, 0, 1);
	apb(1, `MPP_OFF_DESC0, D0, 0, 0);
	apb(1, `MPP_OFF_DESC1, D1, 0, 0);
	apb(1, `MPP_OFF_CTRL, 32'h00140a03, 0, 0);
	apb(0, `MPP_OFF_CTRL, 0, 32'h00140a03, 0);
	seq(1, 3'h2);
	{pa, pb, slow, sched_pri} <= {5'd31, 5'd5, 1'b1, 5'd9};
	seq(4, 3'h2);
	pb <= 31;
	seq(4, 3'h0);
	se <= 0;
	pulse_sched;
	repeat (4) @(posedge pclk);
	chk({busy, tx_req}, 0);
	rx(3, 20, 3'b010);
	rx(10, 20, 3'b010);
	blk <= 1;
	rx(11, 20, 3'b100);
	blk <= 0;
	sus <= 1;
	rx(11, 20, 3'b101);
	tries(4, 3'h0);
	sus <= 0;
	rx(11, 4, 3'b100);
	cur_pri <= 7;
	bc(4'h1, 32'h7);
	bc(4'h2, 32'h14);
	bc(4'h4, 32'h7);
	bc(4'h8, 32'h7);
	complete_run;
end
endmodule
